// file: shared/lcc_pkg.sv
// constants and types shared by the light conversion control block
package lcc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CONV_SHORT_MS = 100;
  localparam int unsigned CONV_LONG_MS = 800;
  localparam int unsigned CONV_SHORT_CYC = CLK_HZ / 1000 * CONV_SHORT_MS;
  localparam int unsigned CONV_LONG_CYC = CLK_HZ / 1000 * CONV_LONG_MS;
  localparam int unsigned RANGE_POS = 12;
  localparam int unsigned CT_POS = 11;
  localparam int unsigned MODE_POS = 9;
  localparam int unsigned DONE_POS = 7;
  localparam logic [3:0] RANGE_AUTO = 4'hc;
  localparam logic [3:0] RANGE_MAX = 4'hb;
  localparam logic [3:0] RANGE_RESET = 4'hc;
  localparam logic CT_RESET = 1'b1;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] LOSS_RANGE_ONE = 4'h5;
  localparam logic [3:0] LOSS_RANGE_THREE = 4'h0;
  typedef enum logic [1:0] {
    LCC_IDLE = 2'b00,
    LCC_CONV = 2'b01,
    LCC_DONE = 2'b11
  } lcc_state_e;
endpackage

// file: design/lcc_top.sv
// conversion control behind the configuration register of a light sensor
//
// Behaviour
// - range select field bits 15:12 picks full-scale range, coded as result exponent.
// - range select 1100b means automatic full-scale mode.
// - in automatic mode the chosen range is reported as result exponent.
// - range select resets to 1100, automatic mode.
// - bit 11 selects 100 ms (0) or 800 ms (1) conversion; resets to 1.
// - short time drops resolution: one bit at 0101b, two at 0100b-0001b, three at 0000b.
// - result format and LSB weight do not depend on conversion time.
// - mode bits 10:9: 00 shutdown, 01 single, 10/11 continuous.
// - mode field resets to 00b, shutdown.
// - single mode reads 01b while converting, then returns to 00b itself.
// - any configuration write aborts a conversion; restart if new mode converts.
// - done flag sets at conversion end, clears on access except shutdown write.
`timescale 1ns/1ns
`default_nettype none
module lcc_top
  import lcc_pkg::*;
#(
  parameter int unsigned SHORT_CYC = CONV_SHORT_CYC,
  parameter int unsigned LONG_CYC = CONV_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic cfg_rd_i,
  input wire logic adc_overflow_i,
  input wire logic [11:0] adc_data_i,
  output logic [15:0] cfg_rdata_o,
  output logic [15:0] result_o,
  output logic [1:0] drop_bits_o,
  output logic converting_o,
  output logic conv_start_o
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] range_q, range_d;
  logic ct_q, ct_d;
  logic [1:0] mode_q, mode_d;
  logic done_q, done_d;
  lcc_state_e st_q, st_d;
  logic [26:0] cnt_q, cnt_d;
  logic [3:0] act_range_q, act_range_d;
  logic [15:0] result_q, result_d;
  logic [1:0] drop_q, drop_d;
  logic start_q, start_d;
  logic [26:0] conv_len;
  logic [1:0] drop_of;
  logic wr_runs;
  // both lengths are parameters so a bench can shorten them; the field only picks one

  always_comb begin
    conv_len = ct_q ? LONG_CYC[26:0] : SHORT_CYC[26:0];
  end

  // resolution loss for the short time only; result format unchanged
  always_comb begin
    drop_of = 2'h0;
    if (!ct_q) begin
      if (act_range_q == LOSS_RANGE_THREE) begin
        drop_of = 2'h3;
      end else if (act_range_q < LOSS_RANGE_ONE) begin
        drop_of = 2'h2;
      end else if (act_range_q == LOSS_RANGE_ONE) begin
        drop_of = 2'h1;
      end
    end
  end

  // decoded from write data so the flag logic can tell shutdown writes apart
  assign wr_runs = cfg_wdata_i[MODE_POS+1 -: 2] != MODE_SHUTDOWN;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    range_d = range_q;
    ct_d = ct_q;
    mode_d = mode_q;
    done_d = done_q;
    st_d = st_q;
    cnt_d = cnt_q;
    act_range_d = act_range_q;
    result_d = result_q;
    drop_d = drop_q;
    start_d = 1'b0;
    // reads and non-shutdown writes clear the flag; a finishing conversion wins over a read below
    if (cfg_rd_i || (cfg_wr_i && wr_runs)) begin
      done_d = 1'b0;
    end
    unique case (st_q)
      LCC_IDLE, LCC_DONE: begin
        st_d = LCC_IDLE;
        if (mode_q != MODE_SHUTDOWN) begin
          st_d = LCC_CONV;
          cnt_d = 27'h0;
          start_d = 1'b1;
          act_range_d = (range_q == RANGE_AUTO) ? RANGE_MAX : range_q;
        end
      end
      LCC_CONV: begin
        if (cnt_q + 27'h1 >= conv_len) begin
          if (range_q == RANGE_AUTO && adc_overflow_i == 1'b0 && act_range_q != 4'h0 &&
              adc_data_i[11:10] == 2'h0) begin
            // auto mode steps down while the signal stays small, then reconverts
            // the mantissa is not rescaled here; the converter answers again at the new range
            act_range_d = act_range_q - 4'h1;
            cnt_d = 27'h0;
            start_d = 1'b1;
          end else begin
            st_d = LCC_DONE;
            done_d = 1'b1;
            result_d = {act_range_q, adc_data_i};
            drop_d = drop_of;
            if (mode_q == MODE_SINGLE) begin
              mode_d = MODE_SHUTDOWN;
            end
          end
        end else begin
          cnt_d = cnt_q + 27'h1;
        end
      end
      default: st_d = LCC_IDLE;
    endcase
    // the write is applied last so that it overrides state, mode and done flag of a conversion ending in the same cycle; result_q and drop_q still load
    if (cfg_wr_i) begin
      range_d = cfg_wdata_i[RANGE_POS+3 -: 4];
      ct_d = cfg_wdata_i[CT_POS];
      mode_d = cfg_wdata_i[MODE_POS+1 -: 2];
      st_d = LCC_IDLE;
      cnt_d = 27'h0;
      start_d = 1'b0;
      done_d = (wr_runs || cfg_rd_i) ? 1'b0 : done_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      range_q <= RANGE_RESET;
      ct_q <= CT_RESET;
      mode_q <= MODE_RESET;
      done_q <= 1'b0;
      st_q <= LCC_IDLE;
      cnt_q <= 27'h0;
      act_range_q <= 4'h0;
      result_q <= 16'h0;
      drop_q <= 2'h0;
      start_q <= 1'b0;
    end else begin
      range_q <= range_d;
      ct_q <= ct_d;
      mode_q <= mode_d;
      done_q <= done_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      act_range_q <= act_range_d;
      result_q <= result_d;
      drop_q <= drop_d;
      start_q <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  logic [15:0] rdata_q;
  logic conv_q;
  // read data is built from next-state values so a read right after a write sees it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'hc800;
      conv_q <= 1'b0;
    end else begin
      rdata_q <= {range_d, ct_d, mode_d, 1'b0, done_d, 7'h0};
      conv_q <= st_d == LCC_CONV;
    end
  end
  assign cfg_rdata_o = rdata_q;
  assign result_o = result_q;
  assign drop_bits_o = drop_q;
  assign converting_o = conv_q;
  assign conv_start_o = start_q;

  ////////////////////////////////////////////////////////////////////////
  // checker helper: length of the running conversion, counted apart from cnt_q
  // so that a broken terminal count in the main path cannot hide itself
  logic [26:0] run_len_q, run_len_d;
  always_comb begin
    run_len_d = run_len_q;
    if (start_q) begin
      run_len_d = 27'h0;
    end else if (conv_q) begin
      run_len_d = run_len_q + 27'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      run_len_q <= 27'h0;
    end else begin
      run_len_q <= run_len_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_RESET_RANGE: assert property (@(posedge clk_i) !resetn_i |=> range_q == RANGE_AUTO && ct_q)
    else $error("range or time not at reset value");
  AST_RESET_MODE: assert property (@(posedge clk_i) !resetn_i |=> mode_q == MODE_SHUTDOWN)
    else $error("mode not shutdown after reset");
  AST_WRITE_FIELDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_wr_i |=> range_q == $past(cfg_wdata_i[15:12]) && ct_q == $past(cfg_wdata_i[11]))
    else $error("written fields not taken");
  AST_WRITE_ABORT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_wr_i |=> st_q == LCC_IDLE ##1 (st_q == LCC_CONV) == (mode_q != MODE_SHUTDOWN))
    else $error("write did not abort and restart");
  AST_SINGLE_END: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE && $past(mode_q) == MODE_SINGLE && !$past(cfg_wr_i) |-> mode_q == MODE_SHUTDOWN)
    else $error("single shot did not return to shutdown");
  AST_DONE_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE |-> done_q)
    else $error("done flag missing at conversion end");
  AST_DONE_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_rd_i && !cfg_wr_i && st_d != LCC_DONE |=> !done_q)
    else $error("read did not clear done flag");
  AST_CONT_RESTART: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE && mode_q[1] && !cfg_wr_i |=> st_q == LCC_CONV)
    else $error("continuous mode did not restart");
  AST_EXPONENT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE && range_q != RANGE_AUTO && !$past(cfg_wr_i) |-> result_q[15:12] == range_q)
    else $error("exponent differs from manual range");
  AST_DROP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE && $past(ct_q) |-> drop_q == 2'h0)
    else $error("long conversion lost resolution");

  // start pulse, conversion length and range stepping, checked independently
  AST_START_PULSE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_q |=> !start_q)
    else $error("start pulse longer than one cycle");

  AST_START_CONV: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_q |-> conv_q)
    else $error("start without converting level");

  AST_CONV_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(conv_q) && !$past(cfg_wr_i) |-> run_len_q == conv_len - 27'h1)
    else $error("conversion length differs from selected time");

  AST_AUTO_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_q && $past(st_q) != LCC_CONV && range_q == RANGE_AUTO |-> act_range_q == RANGE_MAX)
    else $error("auto mode did not start at top range");

  AST_AUTO_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_q && $past(st_q) == LCC_CONV |-> act_range_q == $past(act_range_q) - 4'h1)
    else $error("auto mode did not step down one range");

  AST_MANUAL_RANGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_q && range_q != RANGE_AUTO |-> act_range_q == range_q)
    else $error("manual range not used for conversion");

  AST_DROP_SHORT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE && !$past(ct_q) && $past(act_range_q) == LOSS_RANGE_THREE |-> drop_q == 2'h3)
    else $error("lowest range short time did not lose three bits");

  AST_SHUT_WRITE_KEEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_wr_i && cfg_wdata_i[10:9] == MODE_SHUTDOWN && !cfg_rd_i |=> done_q == $past(done_q))
    else $error("shutdown write changed done flag");

  AST_CONT_KEEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_DONE && mode_q[1] |-> mode_q == $past(mode_q))
    else $error("continuous mode changed at conversion end");

  AST_SINGLE_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_CONV && $past(mode_q) == MODE_SINGLE && !$past(cfg_wr_i) |-> mode_q == MODE_SINGLE)
    else $error("single mode left while converting");

  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q != LCC_DONE |-> $stable(result_q))
    else $error("result changed outside conversion end");

  AST_SHUT_QUIET: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mode_q == MODE_SHUTDOWN && st_q != LCC_CONV |=> !start_q)
    else $error("conversion started in shutdown");

  AST_CONV_MODE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q == LCC_CONV |-> mode_q != MODE_SHUTDOWN)
    else $error("converting while in shutdown");

  COV_SINGLE: cover property (@(posedge clk_i) st_q == LCC_DONE && mode_q == MODE_SHUTDOWN);
  COV_CONT: cover property (@(posedge clk_i) st_q == LCC_DONE && mode_q[1]);
  COV_ABORT: cover property (@(posedge clk_i) st_q == LCC_CONV && cfg_wr_i);
  COV_AUTO_STEP: cover property (@(posedge clk_i) start_q && st_q == LCC_CONV && $past(st_q) == LCC_CONV);
  COV_SHORT_LOSS: cover property (@(posedge clk_i) st_q == LCC_DONE && drop_q == 2'h3);
endmodule
`default_nettype wire

// file: verification/lcc_host_model.sv
// host model that programs the configuration register through its strobes
`timescale 1ns/1ns
`default_nettype none
module lcc_host_model (
  input wire logic clk_i,
  output logic cfg_wr_o,
  output logic [15:0] cfg_wdata_o,
  output logic cfg_rd_o
);
  initial begin
    cfg_wr_o = 1'b0;
    cfg_wdata_o = 16'h0000;
    cfg_rd_o = 1'b0;
  end
  // reserved range codes are never driven with the write strobe; they fall back to auto
  task automatic wr(input logic [15:0] d);
    @(posedge clk_i);
    cfg_wr_o <= 1'b1;
    cfg_wdata_o <= (d[15:12] > 4'hc) ? {4'hc, d[11:0]} : d;
    @(posedge clk_i);
    cfg_wr_o <= 1'b0;
    cfg_wdata_o <= ~cfg_wdata_o;
  endtask
  task automatic rd();
    @(posedge clk_i);
    cfg_rd_o <= 1'b1;
    @(posedge clk_i);
    cfg_rd_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/light_conversion_control_tb_top.sv
// self-checking bench for the light conversion control block
`timescale 1ns/1ns
`default_nettype none
module light_conversion_control_tb_top;
  import lcc_pkg::*;
  logic clk, resetn, wr, rd, ovf, done_q;
  logic [15:0] wdata, rdata, result;
  logic [11:0] adc;
  logic [1:0] drop;
  logic conv_s, start_s;
  logic [31:0] seed = 32'h005c58d6;
  logic [17:0] exp_q[$];
  logic [17:0] exp_v;
  int error_cnt = 0;
  int num_checks = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  lcc_host_model u_host (.clk_i(clk), .cfg_wr_o(wr), .cfg_wdata_o(wdata), .cfg_rd_o(rd));
  lcc_top #(.SHORT_CYC(20), .LONG_CYC(40)) u_dut (.clk_i(clk), .resetn_i(resetn), .cfg_wr_i(wr),
    .cfg_wdata_i(wdata), .cfg_rd_i(rd), .adc_overflow_i(ovf), .adc_data_i(adc), .cfg_rdata_o(rdata),
    .result_o(result), .drop_bits_o(drop), .converting_o(conv_s), .conv_start_o(start_s));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] loss(input logic [3:0] r, input logic ct);
    if (ct || r > 4'h5) return 2'd0;
    return (r == 4'h5) ? 2'd1 : ((r == 4'h0) ? 2'd3 : 2'd2);
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (rdata[7] !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk({rdata[7], conv_s}, 2'b10);
  endtask
  // one conversion: note the result, program, wait, then test flag clearing
  task automatic conv(input logic [3:0] r, input logic ct, input logic [1:0] m);
    seed = xs(seed);
    adc <= {1'b1, seed[10:0]};
    exp_q.push_back({(r == 4'hc) ? 4'hb : r, 1'b1, seed[10:0], loss(r, ct)});
    u_host.wr({r, ct, m, 9'h000});
    @(negedge clk);
    chk(rdata[10:9], m);
    @(negedge clk);
    chk({conv_s, start_s}, 2'b11);
    wait_done();
    u_host.wr({r, ct, 2'b00, 9'h000});
    @(negedge clk);
    chk(rdata, {r, ct, 2'b00, 2'b01, 7'h00});
    u_host.rd();
    @(negedge clk);
    chk(rdata, {r, ct, 2'b00, 9'h000});
  endtask
  // results are matched in the order they were requested
  always @(negedge clk) begin
    if (rdata[7] === 1'b1 && done_q !== 1'b1) begin
      if (exp_q.size() == 0) chk(18'h0, 18'h3ffff);
      else begin
        exp_v = exp_q.pop_front();
        chk({result, drop}, exp_v);
      end
    end
    done_q = rdata[7];
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    resetn <= 1'b0;
    ovf <= 1'b0;
    adc <= 12'h800;
    done_q = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk(rdata, 16'hc800);
    for (int r = 0; r < 13; r++) conv(r[3:0], 1'b0, 2'b01);
    conv(4'hc, 1'b1, 2'b01);
    conv(4'h3, 1'b1, 2'b01);
    // small signal in auto mode walks down to the lowest range; overflow pins it at the top
    adc <= 12'h3a5;
    exp_q.push_back({4'h0, 12'h3a5, 2'd3});
    u_host.wr({4'hc, 1'b0, 2'b01, 9'h000});
    wait_done();
    u_host.rd();
    ovf <= 1'b1;
    exp_q.push_back({4'hb, 12'h3a5, 2'd0});
    u_host.wr({4'hc, 1'b0, 2'b01, 9'h000});
    wait_done();
    u_host.rd();
    ovf <= 1'b0;
    u_host.wr({4'h3, 1'b0, 2'b01, 9'h000});
    repeat (5) @(posedge clk);
    conv(4'h7, 1'b0, 2'b01);
    exp_q.push_back({4'h2, adc, 2'd2});
    exp_q.push_back({4'h2, adc, 2'd2});
    u_host.wr({4'h2, 1'b0, 2'b10, 9'h000});
    wait_done();
    chk(rdata[10:9], 2'b10);
    u_host.rd();
    @(negedge clk);
    wait_done();
    u_host.wr({4'h2, 1'b0, 2'b00, 9'h000});
    u_host.rd();
    repeat (50) @(negedge clk);
    chk(rdata, {4'h2, 1'b0, 2'b00, 9'h000});
    chk(exp_q.size(), 18'h0);
    summarize();
  end
endmodule
`default_nettype wire
